// File: src/pdr_monitor.sv
`timescale 1ns/10ps
// Function
// - switch mode: selected input at its active level means dry run
// - mode selects disabled (default), switch sensing or sensorless power
// - source is none, base or extension input, each usable high or low active
// - power mode: dry run when estimate below curve scaled by factor, default 70%
// - curve is two speed/power points, speed to 500 Hz, power to 327.67 kW
// - signed mechanical power estimate spans -327.68 kW to +327.67 kW
// - curve point settings are shared with the low-flow monitor
// - warning stays asserted while dry-run condition is present
// - error raised when condition lasts longer than error delay, 0..3600 s, default 5
// - after error, restart is blocked until restart delay expires, even if cleared
// - restart delay 10..3600 s, default 60, only when mode is not disabled
// - error and restart inhibit are lost on power cycle
module pdr_monitor
   import pdr_pkg::*;
#(
   parameter int SEC_CYCLES = PDR_SEC_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire pdr_mode_e dryrun_detect_mode,
   input wire logic [PDR_SRC_W-1:0] dryrun_switch_source,
   input wire logic dryrun_switch_active_low,
   input wire logic [PDR_NUM_DI-1:0] base_di,
   input wire logic [PDR_NUM_DI-1:0] ext_di,
   input wire logic signed [PDR_PWR_W-1:0] mech_power_estimate,
   input wire logic [PDR_SPD_W-1:0] motor_speed,
   input wire logic [PDR_PWR_W-1:0] noflow_low_power,
   input wire logic [PDR_SPD_W-1:0] noflow_low_speed,
   input wire logic [PDR_PWR_W-1:0] noflow_high_power,
   input wire logic [PDR_SPD_W-1:0] noflow_high_speed,
   input wire logic [PDR_PCT_W-1:0] dryrun_margin_factor,
   input wire logic [PDR_SEC_W-1:0] dryrun_error_delay,
   input wire logic [PDR_SEC_W-1:0] dryrun_restart_delay,
   input wire logic error_clear,
   output logic dryrun_warning_flag,
   output logic dryrun_error_flag,
   output logic restart_inhibit,
   output logic [PDR_PWR_W-1:0] noflow_low_power_out,
   output logic [PDR_SPD_W-1:0] noflow_low_speed_out,
   output logic [PDR_PWR_W-1:0] noflow_high_power_out,
   output logic [PDR_SPD_W-1:0] noflow_high_speed_out
);
   import pdr_pkg::*;

   localparam int TICK_W = $clog2(SEC_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SEC_CYCLES - 1);

   // ---- pin inputs through synchronisers
   logic [PDR_NUM_DI-1:0] base_s, ext_s;

   pdr_sync #(.WIDTH(2 * PDR_NUM_DI)) u_sync (
      .clk(clk),
      .reset(reset),
      .async_in({ext_di, base_di}),
      .sync_out({ext_s, base_s})
   );

   // ---- switch selection
   wire logic src_is_base = (dryrun_switch_source >= PDR_SRC_BASE_FIRST) &&
                            (dryrun_switch_source < PDR_SRC_EXT_FIRST);
   wire logic src_is_ext = (dryrun_switch_source >= PDR_SRC_EXT_FIRST) &&
                           (dryrun_switch_source <= PDR_SRC_LAST);
   wire logic [PDR_SRC_W-1:0] base_idx = dryrun_switch_source - PDR_SRC_BASE_FIRST;
   wire logic [PDR_SRC_W-1:0] ext_idx = dryrun_switch_source - PDR_SRC_EXT_FIRST;
   wire logic sel_raw = src_is_base ? base_s[base_idx[2:0]] :
                        src_is_ext ? ext_s[ext_idx[2:0]] : 1'b0;
   // none selected never reports dry run, whatever the polarity
   wire logic switch_dry = (src_is_base || src_is_ext) &&
                           (sel_raw ^ dryrun_switch_active_low);

   // ---- no-flow curve, shared with the low-flow monitor
   assign noflow_low_power_out = noflow_low_power;
   assign noflow_low_speed_out = noflow_low_speed;
   assign noflow_high_power_out = noflow_high_power;
   assign noflow_high_speed_out = noflow_high_speed;

   // settings clamped to their ranges
   wire logic [PDR_SPD_W-1:0] spd_lo =
      (noflow_low_speed > PDR_SPEED_MAX) ? PDR_SPEED_MAX : noflow_low_speed;
   wire logic [PDR_SPD_W-1:0] spd_hi =
      (noflow_high_speed > PDR_SPEED_MAX) ? PDR_SPEED_MAX : noflow_high_speed;
   wire logic [PDR_PWR_W-1:0] pwr_lo =
      (noflow_low_power > PDR_POWER_MAX) ? PDR_POWER_MAX : noflow_low_power;
   wire logic [PDR_PWR_W-1:0] pwr_hi =
      (noflow_high_power > PDR_POWER_MAX) ? PDR_POWER_MAX : noflow_high_power;
   wire logic [PDR_PCT_W-1:0] factor =
      (dryrun_margin_factor > PDR_PCT_MAX) ? PDR_PCT_MAX : dryrun_margin_factor;

   // interpolation, held flat outside the two points
   wire logic [PDR_SPD_W-1:0] spd =
      (motor_speed < spd_lo) ? spd_lo : (motor_speed > spd_hi) ? spd_hi : motor_speed;
   wire logic [PDR_SPD_W-1:0] spd_span = (spd_hi > spd_lo) ? (spd_hi - spd_lo) : '0;
   wire logic [PDR_SPD_W-1:0] spd_off = (spd_hi > spd_lo) ? (spd - spd_lo) : '0;
   wire logic signed [PDR_PWR_W:0] pwr_delta =
      $signed({1'b0, pwr_hi}) - $signed({1'b0, pwr_lo});

   // registered pipeline: product, divide, scale
   logic signed [PDR_PWR_W+PDR_SPD_W+1:0] prod_r;
   logic [PDR_SPD_W-1:0] span_r;
   logic [PDR_PWR_W-1:0] base_pwr_r;
   logic [PDR_PWR_W-1:0] curve_r;
   logic [PDR_PWR_W+PDR_PCT_W-1:0] limit_r;
   logic signed [PDR_PWR_W-1:0] est_r, est2_r;
   logic power_dry_r;

   wire logic signed [PDR_PWR_W+PDR_SPD_W+1:0] quot =
      (span_r == '0) ? '0 : prod_r / $signed({1'b0, span_r});
   wire logic signed [PDR_PWR_W+PDR_SPD_W+1:0] curve_sum =
      $signed({{(PDR_SPD_W+2){1'b0}}, base_pwr_r}) + quot;
   wire logic [PDR_PWR_W-1:0] curve_val = curve_sum[PDR_PWR_W-1:0];
   wire logic [PDR_PWR_W+PDR_PCT_W-1:0] est_scaled =
      (est2_r[PDR_PWR_W-1]) ? '0 :
      (PDR_PWR_W+PDR_PCT_W)'(est2_r) * (PDR_PWR_W+PDR_PCT_W)'(PDR_PCT_MAX);

   always_ff @(posedge clk) begin
      if (reset) begin
         prod_r <= '0;
         span_r <= '0;
         base_pwr_r <= '0;
         est_r <= '0;
      end else begin
         prod_r <= pwr_delta * $signed({1'b0, spd_off});
         span_r <= spd_span;
         base_pwr_r <= pwr_lo;
         est_r <= mech_power_estimate;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         curve_r <= '0;
         limit_r <= '0;
         est2_r <= '0;
         power_dry_r <= 1'b0;
      end else begin
         curve_r <= curve_val;
         est2_r <= est_r;
         limit_r <= curve_r * factor;
         // estimate*100 below curve*factor; negative estimates count as zero
         power_dry_r <= est_scaled < limit_r;
      end
   end

   // ---- condition by mode
   wire logic mode_on = (dryrun_detect_mode != PDR_MODE_DISABLED);
   logic condition;
   always_comb begin
      unique case (dryrun_detect_mode)
         PDR_MODE_SWITCH_SENSING: condition = switch_dry;
         PDR_MODE_SENSORLESS_POWER: condition = power_dry_r;
         default: condition = 1'b0;
      endcase
   end

   // ---- seconds time base
   logic [TICK_W-1:0] tick_cnt_r;
   wire logic sec_tick = (tick_cnt_r == TICK_LAST);
   always_ff @(posedge clk) begin
      if (reset) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= sec_tick ? '0 : tick_cnt_r + 1'b1;
      end
   end

   // ---- error delay
   wire logic [PDR_SEC_W-1:0] err_delay =
      (dryrun_error_delay > PDR_DELAY_MAX) ? PDR_DELAY_MAX : dryrun_error_delay;
   logic [PDR_SEC_W-1:0] err_sec_r;
   logic [PDR_SEC_W-1:0] err_sec_nxt;
   wire logic delay_done = (err_sec_r >= err_delay);
   always_comb begin
      if (!condition) begin
         err_sec_nxt = '0;
      end else if (sec_tick && !delay_done) begin
         err_sec_nxt = err_sec_r + 1'b1;
      end else begin
         err_sec_nxt = err_sec_r;
      end
   end
   // a zero delay fires on the first cycle of the condition
   wire logic err_fire = condition && delay_done &&
                         ((err_delay == '0) || sec_tick);

   // ---- restart delay
   wire logic [PDR_SEC_W-1:0] rst_delay =
      (dryrun_restart_delay < PDR_RESTART_MIN) ? PDR_RESTART_MIN :
      (dryrun_restart_delay > PDR_DELAY_MAX) ? PDR_DELAY_MAX : dryrun_restart_delay;
   logic [PDR_SEC_W-1:0] rst_sec_r;
   logic error_r, inhibit_r;

   always_ff @(posedge clk) begin
      // synchronous reset doubles as power-on reset: nothing survives it
      if (reset) begin
         err_sec_r <= '0;
         error_r <= 1'b0;
         inhibit_r <= 1'b0;
         rst_sec_r <= '0;
      end else begin
         err_sec_r <= err_sec_nxt;
         // a new firing wins over a clear in the same cycle
         if (err_fire) begin
            error_r <= 1'b1;
         end else if (error_clear) begin
            error_r <= 1'b0;
         end
         if (!mode_on) begin
            inhibit_r <= 1'b0;
            rst_sec_r <= '0;
         end else if (err_fire) begin
            inhibit_r <= 1'b1;
            rst_sec_r <= '0;
         end else if (inhibit_r && sec_tick) begin
            if (rst_sec_r + 1'b1 >= rst_delay) begin
               inhibit_r <= 1'b0;
            end
            rst_sec_r <= rst_sec_r + 1'b1;
         end
      end
   end

   assign dryrun_warning_flag = condition;
   assign dryrun_error_flag = error_r;
   assign restart_inhibit = inhibit_r;
endmodule

// File: src/pdr_pkg.sv
package pdr_pkg;
   typedef enum logic [1:0] {
      PDR_MODE_DISABLED,
      PDR_MODE_SWITCH_SENSING,
      PDR_MODE_SENSORLESS_POWER
   } pdr_mode_e;

   // switch source: 0 none, 1..6 base inputs, 7..12 extension inputs
   localparam int PDR_SRC_W = 4;
   localparam logic [PDR_SRC_W-1:0] PDR_SRC_NONE = 4'h0;
   localparam logic [PDR_SRC_W-1:0] PDR_SRC_BASE_FIRST = 4'h1;
   localparam logic [PDR_SRC_W-1:0] PDR_SRC_EXT_FIRST = 4'h7;
   localparam logic [PDR_SRC_W-1:0] PDR_SRC_LAST = 4'hc;
   localparam int PDR_NUM_DI = 6;

   // power in 0.01 kW, speed in 0.1 Hz, factor in percent
   localparam int PDR_PWR_W = 16;
   localparam int PDR_SPD_W = 13;
   localparam int PDR_PCT_W = 7;
   localparam int PDR_SEC_W = 12;
   localparam logic [PDR_SPD_W-1:0] PDR_SPEED_MAX = 13'h1388;
   localparam logic [PDR_PWR_W-1:0] PDR_POWER_MAX = 16'h7fff;
   localparam logic [PDR_PCT_W-1:0] PDR_PCT_MAX = 7'h64;
   localparam logic [PDR_SEC_W-1:0] PDR_DELAY_MAX = 12'he10;
   localparam logic [PDR_SEC_W-1:0] PDR_RESTART_MIN = 12'h00a;

   localparam logic [PDR_SEC_W-1:0] PDR_ERR_DELAY_RST = 12'h005;
   localparam logic [PDR_SEC_W-1:0] PDR_RESTART_DELAY_RST = 12'h03c;
   localparam logic [PDR_PCT_W-1:0] PDR_FACTOR_RST = 7'h46;

   localparam int PDR_CLK_HZ = 40000000;
   localparam int PDR_SEC_TICK_S = 1;
   localparam int PDR_SEC_CYCLES = PDR_CLK_HZ * PDR_SEC_TICK_S;
endpackage

// File: src/pdr_sync.sv
`timescale 1ns/10ps
// three-stage input synchroniser; the output follows once stages two and three agree
module pdr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
   // a bit follows stage three only where stages two and three agree
   wire logic [WIDTH-1:0] agree = ~(s2_r ^ s3_r);
   wire logic [WIDTH-1:0] out_nxt = (agree & s3_r) | (~agree & out_r);

   always_ff @(posedge clk) begin
      if (reset) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         out_r <= '0;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         out_r <= out_nxt;
      end
   end

   assign sync_out = out_r;
endmodule

// File: testbench/pdr_monitor_properties.sv
`timescale 1ns/10ps
module pdr_monitor_checker
   import pdr_pkg::*;
#(
   parameter int SEC_CYCLES = PDR_SEC_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire pdr_mode_e dryrun_detect_mode,
   input wire logic [PDR_SEC_W-1:0] dryrun_error_delay,
   input wire logic error_clear,
   input wire logic [PDR_PWR_W-1:0] noflow_low_power,
   input wire logic [PDR_SPD_W-1:0] noflow_high_speed,
   input wire logic dryrun_warning_flag,
   input wire logic dryrun_error_flag,
   input wire logic restart_inhibit,
   input wire logic [PDR_PWR_W-1:0] noflow_low_power_out,
   input wire logic [PDR_SPD_W-1:0] noflow_high_speed_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire off = dryrun_detect_mode == PDR_MODE_DISABLED;
   chk_warn_disabled: assert property (off [*5] |-> !dryrun_warning_flag)
      else $error("warning while detection disabled");
   chk_inh_disabled: assert property (off [*3] |-> !restart_inhibit)
      else $error("inhibit while detection disabled");
   chk_err_needs_cond: assert property
      ($rose(dryrun_error_flag) |-> $past(dryrun_warning_flag))
      else $error("error without dry-run condition");
   chk_err_after_delay: assert property
      ($rose(dryrun_error_flag) && dryrun_error_delay != 12'h000
      |-> $past(dryrun_warning_flag, SEC_CYCLES))
      else $error("error before the delay could elapse");
   chk_inh_on_err: assert property ($rose(dryrun_error_flag) |-> restart_inhibit)
      else $error("error without restart inhibit");
   chk_inh_holds: assert property
      ($rose(restart_inhibit) ##1 (!off) [*8] |-> restart_inhibit)
      else $error("restart inhibit dropped early");
   chk_err_stands: assert property
      (dryrun_error_flag && !error_clear |=> dryrun_error_flag)
      else $error("error dropped without clear");
   chk_clear_drops_err: assert property
      (error_clear && !dryrun_warning_flag |=> !dryrun_error_flag)
      else $error("error survived clear");
   chk_curve_power: assert property
      (noflow_low_power <= PDR_POWER_MAX |-> noflow_low_power_out == noflow_low_power)
      else $error("low power not shared");
   chk_curve_speed: assert property
      (noflow_high_speed <= PDR_SPEED_MAX |-> noflow_high_speed_out == noflow_high_speed)
      else $error("high speed not shared");
endmodule
bind pdr_monitor pdr_monitor_checker #(.SEC_CYCLES(SEC_CYCLES)) u_chk (
   .clk, .reset, .dryrun_detect_mode, .dryrun_error_delay, .error_clear, .noflow_low_power,
   .noflow_high_speed, .dryrun_warning_flag, .dryrun_error_flag, .restart_inhibit,
   .noflow_low_power_out, .noflow_high_speed_out
);

// File: testbench/pdr_far_side.sv
`timescale 1ns/10ps
module pdr_far_side
   import pdr_pkg::*;
(
   input wire logic clk,
   input wire logic [2*PDR_NUM_DI-1:0] pin_level,
   input wire logic signed [PDR_PWR_W-1:0] power_level,
   output logic [PDR_NUM_DI-1:0] base_di,
   output logic [PDR_NUM_DI-1:0] ext_di,
   output logic signed [PDR_PWR_W-1:0] mech_power_estimate
);
   // switch contacts and estimator settle one clock after a change
   always_ff @(posedge clk) begin
      {ext_di, base_di} <= pin_level;
      mech_power_estimate <= power_level;
   end
endmodule

// File: testbench/tb.sv
`timescale 1ns/10ps
module tb;
   import pdr_pkg::*;
   logic clk = 1'b0, reset = 1'b1, alow = 1'b0, clr = 1'b0;
   pdr_mode_e mode = PDR_MODE_DISABLED;
   logic [PDR_SRC_W-1:0] src = 4'h0;
   logic [11:0] pins = 12'h000;
   logic signed [PDR_PWR_W-1:0] sensorless_power = 16'sh0000;
   logic [PDR_SEC_W-1:0] edly = PDR_DELAY_MAX, rdly = PDR_RESTART_MIN;
   logic [PDR_PCT_W-1:0] fac = PDR_FACTOR_RST;
   logic [PDR_SPD_W-1:0] spd = 13'h01f4, lo_s = 13'h0000, hi_s = PDR_SPEED_MAX;
   logic [PDR_PWR_W-1:0] lo_p = 16'h2710, hi_p = 16'h2710;
   wire [PDR_NUM_DI-1:0] bdi, edi;
   wire signed [PDR_PWR_W-1:0] est;
   wire warn, err, inh;
   wire [PDR_PWR_W-1:0] lpo, hpo;
   wire [PDR_SPD_W-1:0] lso, hso;
   int failures = 0, n_checks = 0;
   initial forever #12.5 clk = ~clk;
   pdr_far_side far (.clk(clk), .pin_level(pins), .power_level(sensorless_power), .base_di(bdi),
      .ext_di(edi), .mech_power_estimate(est));
   pdr_monitor #(.SEC_CYCLES(10)) dut (.clk(clk), .reset(reset), .dryrun_detect_mode(mode),
      .dryrun_switch_source(src), .dryrun_switch_active_low(alow), .base_di(bdi), .ext_di(edi),
      .mech_power_estimate(est), .motor_speed(spd), .noflow_low_power(lo_p),
      .noflow_low_speed(lo_s), .noflow_high_power(hi_p), .noflow_high_speed(hi_s),
      .dryrun_margin_factor(fac), .dryrun_error_delay(edly), .dryrun_restart_delay(rdly),
      .error_clear(clr), .dryrun_warning_flag(warn), .dryrun_error_flag(err),
      .restart_inhibit(inh), .noflow_low_power_out(lpo), .noflow_low_speed_out(lso),
      .noflow_high_power_out(hpo), .noflow_high_speed_out(hso));
   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: %s is %b, expected %b", $time, what, got, exp);
      end
   endtask
   function automatic logic flag(input int k);
      return (k == 0) ? warn : (k == 1) ? err : inh;
   endfunction
   // k: 0 warning, 1 error, 2 inhibit; a wait that runs out ends the run
   task automatic wait_flag(input int k, input logic exp, input int n);
      for (int i = 0; i < n && flag(k) !== exp; i++) @(posedge clk);
      chk(flag(k), exp, "awaited flag");
      if (flag(k) !== exp) final_report();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   initial begin
      cyc(3);
      reset <= 1'b0;
      cyc(1);
      chk(warn | err | inh, 1'b0, "flags after reset");
      chk(lpo == lo_p && hpo == hi_p && lso == lo_s && hso == hi_s, 1'b1, "shared curve");
      mode <= PDR_MODE_SWITCH_SENSING;
      for (int s = 1; s <= 12; s++) begin
         src <= s[PDR_SRC_W-1:0];
         pins <= 12'h001 << (s - 1);
         wait_flag(0, 1'b1, 8);
         pins <= 12'h000;
         wait_flag(0, 1'b0, 8);
      end
      src <= PDR_SRC_EXT_FIRST;
      alow <= 1'b1;
      pins <= 12'hfff;
      cyc(8);
      chk(warn, 1'b0, "active-low idle");
      pins <= 12'hfbf;
      wait_flag(0, 1'b1, 8);
      src <= PDR_SRC_NONE;
      alow <= 1'b0;
      pins <= 12'hfff;
      cyc(8);
      chk(warn, 1'b0, "no source");
      src <= PDR_SRC_BASE_FIRST;
      edly <= 12'h002;
      repeat (4) begin
         pins <= 12'h001;
         cyc(15);
         pins <= 12'h000;
         cyc(8);
      end
      chk(err, 1'b0, "error after short bursts");
      pins <= 12'h001;
      cyc(19);
      chk(err, 1'b0, "error before delay");
      wait_flag(1, 1'b1, 40);
      chk(inh, 1'b1, "inhibit at error");
      clr <= 1'b1;
      pins <= 12'h000;
      cyc(2);
      clr <= 1'b0;
      chk(err, 1'b0, "error cleared");
      cyc(85);
      chk(inh, 1'b1, "inhibit inside restart delay");
      wait_flag(2, 1'b0, 40);
      pins <= 12'h001;
      wait_flag(1, 1'b1, 50);
      mode <= PDR_MODE_DISABLED;
      wait_flag(2, 1'b0, 8);
      chk(warn, 1'b0, "warning when disabled");
      mode <= PDR_MODE_SWITCH_SENSING;
      // the error still stands, so wait for the new firing to re-arm the inhibit
      wait_flag(2, 1'b1, 50);
      reset <= 1'b1;
      cyc(2);
      chk(err | inh, 1'b0, "flags after second reset");
      reset <= 1'b0;
      pins <= 12'h000;
      edly <= PDR_DELAY_MAX;
      src <= PDR_SRC_NONE;
      mode <= PDR_MODE_SENSORLESS_POWER;
      sensorless_power <= 16'sd6999;
      wait_flag(0, 1'b1, 8);
      sensorless_power <= 16'sd7000;
      wait_flag(0, 1'b0, 8);
      sensorless_power <= -16'sd1;
      wait_flag(0, 1'b1, 8);
      fac <= 7'h00;
      sensorless_power <= 16'sh0000;
      wait_flag(0, 1'b0, 8);
      // sloped curve: 100 kW at 0 Hz, 200 kW at 500 Hz, midpoint 150 kW
      hi_p <= 16'h4e20;
      spd <= 13'h09c4;
      sensorless_power <= 16'sd10500;
      cyc(8);
      fac <= PDR_FACTOR_RST;
      cyc(8);
      chk(warn, 1'b0, "curve midpoint at limit");
      sensorless_power <= 16'sd10499;
      wait_flag(0, 1'b1, 8);
      // speed above the high point holds the curve flat at 200 kW
      spd <= 13'h1fff;
      sensorless_power <= 16'sd13999;
      cyc(8);
      chk(warn, 1'b1, "curve held flat above high point");
      sensorless_power <= 16'sd14000;
      wait_flag(0, 1'b0, 8);
      final_report();
   end
endmodule
